// [core/scp_defs.svh]
// constants of the serial control port: link timing, addresses, register map
// included by both ends; no logic here
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// system clock and link timing
`define SCP_CLK_NS 4
`define SCP_FILT_NS 50
`define SCP_FILT_LAST 4'((`SCP_FILT_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS - 1)
// clock high and low phases must outlast the pulse filter
`define SCP_SCL_NS 256
`define SCP_QTR_LAST 4'(`SCP_SCL_NS / `SCP_CLK_NS / 4 - 1)

// link framing
`define SCP_BYTE_BITS 4'h8
`define SCP_ACK_SLOT 4'h8
// upper six address bits, value arbitrary
`define SCP_ADDR_HI 6'h2A

// device register map
`define SCP_MODE0_IDX 7'h00
`define SCP_REG_TOP 7'h00
`define SCP_PTR_MAX 7'h7F
`define SCP_MODE0_RST 8'h00
`define SCP_VSTD_RNG 1:0
`define SCP_LUMA_RNG 4:2
`define SCP_CHROMA_RNG 7:5

// host register map (byte addresses) and command bits
`define SCP_H_CMD_OFS 4'h0
`define SCP_H_STAT_OFS 4'h4
`define SCP_H_RX_OFS 4'h8
`define SCP_CMD_DATA_RNG 7:0
`define SCP_CMD_START 8
`define SCP_CMD_STOP 9
`define SCP_CMD_READ 10
`define SCP_CMD_NACK 11

`endif

// [core/scp_pkg.sv]
// types shared by both ends of the serial control port
// assumes nothing of its surroundings
`default_nettype none

package scp_pkg;

  // gray codes along the usual path
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADDR = 4'h1,
    S_ADDR_ACK = 4'h3,
    S_PTR = 4'h2,
    S_PTR_ACK = 4'h6,
    S_WDATA = 4'h7,
    S_WACK = 4'h5,
    S_RDATA = 4'h4,
    S_RACK = 4'hC
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_DATA = 2'h3,
    H_STOP = 2'h2
  } host_state_t;

endpackage : scp_pkg

`default_nettype wire

// [core/scp_link_if.sv]
// two-wire link between controller and device, open-drain with pull-ups
// assumes each end drives low only while its enable is high
`timescale 1ns/1ps
`default_nettype none

interface scp_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-ups
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface : scp_link_if

`default_nettype wire

// [core/scp_device.sv]
// device end of the serial control port with the first mode register
// assumes a controller on the link that makes the serial clock
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"

module scp_device
  import scp_pkg::*;
(
  // link
  scp_link_if.device link,
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // straps
  input wire logic addr_select_pin,
  // mode register fields
  output logic [1:0] video_standard_field,
  output logic [2:0] luma_filter_field,
  output logic [2:0] chroma_filter_field
);

  logic [1:0] line_m_r;
  logic [1:0] line_s_r;
  logic sel_m_r;
  logic sel_s_r;
  logic [1:0] filt_r;
  logic [1:0] prev_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  dev_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shreg_r;
  logic [6:0] ptr_r;
  logic [6:0] ptr_nxt;
  logic rw_r;
  logic sda_oe_r;
  logic mack_r;
  logic [6:0] own_addr;
  logic ptr_ok;
  logic byte_end;
  logic wr_en;
  logic [7:0] mode0_r;
  logic [7:0] rd_byte;

  // two-stage synchronisers, index 1 clock, index 0 data
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      line_m_r <= 2'h3;
      line_s_r <= 2'h3;
      sel_m_r <= 1'b0;
      sel_s_r <= 1'b0;
    end
    else
    begin
      line_m_r <= {link.scl, link.sda};
      line_s_r <= line_m_r;
      sel_m_r <= addr_select_pin;
      sel_s_r <= sel_m_r;
    end
  end

  // glitch filter, one per line, bypassed while addr_select_pin is low
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_filt
      logic [3:0] cnt_r;
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          cnt_r <= 4'h0;
          filt_r[gi] <= 1'b1;
        end
        else if (line_s_r[gi] == filt_r[gi])
          cnt_r <= 4'h0;
        else if (!sel_s_r || cnt_r == `SCP_FILT_LAST)
        begin
          cnt_r <= 4'h0;
          filt_r[gi] <= line_s_r[gi];
        end
        else
          cnt_r <= cnt_r + 4'h1;
      end
    end
  endgenerate

  // edge and condition detection
  always_ff @(posedge clk)
  begin
    if (!resetn)
      prev_r <= 2'h3;
    else
      prev_r <= filt_r;
  end

  assign scl_rise = filt_r[1] & ~prev_r[1];
  assign scl_fall = ~filt_r[1] & prev_r[1];
  assign start_c = filt_r[1] & prev_r[1] & prev_r[0] & ~filt_r[0];
  assign stop_c = filt_r[1] & prev_r[1] & ~prev_r[0] & filt_r[0];

  assign own_addr = {`SCP_ADDR_HI, sel_s_r};
  assign ptr_ok = ~shreg_r[7] && (shreg_r[6:0] <= `SCP_REG_TOP);
  assign ptr_nxt = (ptr_r == `SCP_PTR_MAX) ? ptr_r : ptr_r + 7'h01;
  assign byte_end = scl_fall && (bit_cnt_r == `SCP_BYTE_BITS);
  assign wr_en = (state_r == S_WDATA) && byte_end && !start_c && !stop_c &&
                 (ptr_r == `SCP_MODE0_IDX);

  // read mux, clamped to the highest register
  always_comb
  begin
    rd_byte = 8'h00;
    if (ptr_r >= `SCP_REG_TOP || ptr_r == `SCP_MODE0_IDX)
      rd_byte = mode0_r;
  end

  // link protocol engine
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= S_IDLE;
      bit_cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      ptr_r <= 7'h00;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
      mack_r <= 1'b0;
    end
    else if (start_c)
    begin
      state_r <= S_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_c)
    begin
      state_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        S_ADDR, S_PTR, S_WDATA:
        begin
          if (scl_rise)
          begin
            shreg_r <= {shreg_r[6:0], filt_r[0]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (byte_end)
          begin
            bit_cnt_r <= 4'h0;
            if (state_r == S_ADDR)
            begin
              if (shreg_r[7:1] == own_addr)
              begin
                rw_r <= shreg_r[0];
                sda_oe_r <= 1'b1;
                state_r <= S_ADDR_ACK;
              end
              else
                state_r <= S_IDLE;
            end
            else if (state_r == S_PTR)
            begin
              if (ptr_ok)
              begin
                ptr_r <= shreg_r[6:0];
                sda_oe_r <= 1'b1;
                state_r <= S_PTR_ACK;
              end
              else
                state_r <= S_IDLE;
            end
            else if (ptr_r <= `SCP_REG_TOP)
            begin
              ptr_r <= ptr_nxt;
              sda_oe_r <= 1'b1;
              state_r <= S_WACK;
            end
            else
              state_r <= S_IDLE;
          end
        end
        S_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_r)
            begin
              shreg_r <= {rd_byte[6:0], 1'b0};
              sda_oe_r <= ~rd_byte[7];
              state_r <= S_RDATA;
            end
            else
            begin
              sda_oe_r <= 1'b0;
              state_r <= S_PTR;
            end
          end
        end
        S_PTR_ACK, S_WACK:
        begin
          if (scl_fall)
          begin
            sda_oe_r <= 1'b0;
            state_r <= S_WDATA;
          end
        end
        S_RDATA:
        begin
          if (scl_rise)
            bit_cnt_r <= bit_cnt_r + 4'h1;
          else if (byte_end)
          begin
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            ptr_r <= ptr_nxt;
            state_r <= S_RACK;
          end
          else if (scl_fall)
          begin
            sda_oe_r <= ~shreg_r[7];
            shreg_r <= {shreg_r[6:0], 1'b0};
          end
        end
        S_RACK:
        begin
          if (scl_rise)
            mack_r <= ~filt_r[0];
          else if (scl_fall)
          begin
            if (mack_r)
            begin
              shreg_r <= {rd_byte[6:0], 1'b0};
              sda_oe_r <= ~rd_byte[7];
              state_r <= S_RDATA;
            end
            else
              state_r <= S_IDLE;
          end
        end
        S_IDLE:
          sda_oe_r <= 1'b0;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // first mode register
  always_ff @(posedge clk)
  begin
    if (!resetn)
      mode0_r <= `SCP_MODE0_RST;
    else if (wr_en)
      mode0_r <= shreg_r;
  end

  assign video_standard_field = mode0_r[`SCP_VSTD_RNG];
  assign luma_filter_field = mode0_r[`SCP_LUMA_RNG];
  assign chroma_filter_field = mode0_r[`SCP_CHROMA_RNG];

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_r;

endmodule : scp_device

`default_nettype wire

// [core/scp_host.sv]
// controller end of the serial control port, driven over avalon-mm
// assumes one device on the link and software that sequences the bytes
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"

module scp_host
  import scp_pkg::*;
(
  // link
  scp_link_if.host link,
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  host_state_t state_r;
  logic [3:0] qcnt_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic stop_r;
  logic rd_r;
  logic nack_r;
  logic ack_r;
  logic scl_low_r;
  logic sda_low_r;
  logic sda_m_r;
  logic sda_s_r;
  logic busy;
  logic tick;
  logic cmd_go;
  logic rd_valid_r;
  logic [31:0] readdata_r;

  assign busy = (state_r != H_IDLE);
  assign tick = (qcnt_r == `SCP_QTR_LAST);
  assign cmd_go = write && (address == `SCP_H_CMD_OFS) && !busy &&
                  (byteenable[1:0] == 2'h3);
  assign waitrequest = (read && !rd_valid_r) ||
                       (write && (address == `SCP_H_CMD_OFS) && busy);

  // data line synchroniser
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end
    else
    begin
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
    end
  end

  // quarter-period divider for the serial clock
  always_ff @(posedge clk)
  begin
    if (!resetn || !busy || tick)
      qcnt_r <= 4'h0;
    else
      qcnt_r <= qcnt_r + 4'h1;
  end

  // bit sequencer
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= H_IDLE;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      stop_r <= 1'b0;
      rd_r <= 1'b0;
      nack_r <= 1'b0;
      ack_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end
    else if (cmd_go)
    begin
      tx_r <= writedata[`SCP_CMD_DATA_RNG];
      stop_r <= writedata[`SCP_CMD_STOP];
      rd_r <= writedata[`SCP_CMD_READ];
      nack_r <= writedata[`SCP_CMD_NACK];
      q_r <= 2'h0;
      bit_r <= 4'h0;
      state_r <= writedata[`SCP_CMD_START] ? H_START : H_DATA;
    end
    else if (busy && tick)
    begin
      q_r <= q_r + 2'h1;
      case (state_r)
        H_START:
        begin
          if (q_r == 2'h0)
          begin
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
          end
          else if (q_r == 2'h2)
            sda_low_r <= 1'b1;
          else if (q_r == 2'h3)
          begin
            scl_low_r <= 1'b1;
            state_r <= H_DATA;
          end
        end
        H_DATA:
        begin
          if (q_r == 2'h0)
          begin
            scl_low_r <= 1'b1;
            if (bit_r == `SCP_ACK_SLOT)
              sda_low_r <= rd_r && !nack_r;
            else
              sda_low_r <= !rd_r && !tx_r[7];
          end
          else if (q_r == 2'h1)
            scl_low_r <= 1'b0;
          else if (q_r == 2'h2)
          begin
            if (bit_r != `SCP_ACK_SLOT)
              rx_r <= {rx_r[6:0], sda_s_r};
            else if (!rd_r)
              ack_r <= !sda_s_r;
          end
          else
          begin
            scl_low_r <= 1'b1;
            tx_r <= {tx_r[6:0], 1'b0};
            bit_r <= bit_r + 4'h1;
            if (bit_r == `SCP_ACK_SLOT)
              state_r <= stop_r ? H_STOP : H_IDLE;
          end
        end
        H_STOP:
        begin
          if (q_r == 2'h0)
          begin
            scl_low_r <= 1'b1;
            sda_low_r <= 1'b1;
          end
          else if (q_r == 2'h1)
            scl_low_r <= 1'b0;
          else if (q_r == 2'h2)
            sda_low_r <= 1'b0;
          else
            state_r <= H_IDLE;
        end
        default:
          state_r <= H_IDLE;
      endcase
    end
  end

  // register reads, one wait cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_valid_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end
    else
    begin
      rd_valid_r <= read && !rd_valid_r;
      case (address)
        `SCP_H_STAT_OFS: readdata_r <= {30'h0000_0000, ack_r, busy};
        `SCP_H_RX_OFS: readdata_r <= {24'h00_0000, rx_r};
        default: readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign readdata = readdata_r;
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = scl_low_r;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_low_r;

endmodule : scp_host

`default_nettype wire

// [testbench/scp_link_properties.sv]
// checker on the two-wire link between controller and device
// assumes the interface nets and the system clock of both ends
`timescale 1ns/1ps
`default_nettype none

module scp_link_properties (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] cnt_r;
  logic first_r;
  logic quiet_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // clock rises in a byte, first byte, slot left unacked
  // 9 is the ack slot, A a bit that may carry start or stop
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_r <= 4'h0;
      first_r <= 1'b0;
      quiet_r <= 1'b0;
    end
    else if (scl && $fell(sda))
    begin
      cnt_r <= 4'h0;
      first_r <= 1'b1;
      quiet_r <= 1'b0;
    end
    else if ($rose(scl))
    begin
      if (cnt_r == 4'h9)
        cnt_r <= 4'hA;
      else if (cnt_r == 4'hA)
        cnt_r <= 4'h2;
      else
        cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'h8)
      begin
        first_r <= 1'b0;
        quiet_r <= quiet_r | sda;
      end
    end
  end

  property p_addr_listen;
    first_r && cnt_r < 4'h8 |-> !dev_sda_oe;
  endproperty
  a_addr_listen: assert property (p_addr_listen)
    else $error("device drove during address bits");

  property p_ack_hold;
    $rose(scl) && cnt_r == 4'h8 && dev_sda_oe |-> dev_sda_oe[*6];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack dropped during ninth pulse");

  property p_oe_min;
    $rose(dev_sda_oe) |-> dev_sda_oe[*8];
  endproperty
  a_oe_min: assert property (p_oe_min)
    else $error("device drive too short");

  property p_nack_idle;
    quiet_r |-> !dev_sda_oe;
  endproperty
  a_nack_idle: assert property (p_nack_idle)
    else $error("device drove after unacked slot");

  property p_stop_idle;
    scl && $rose(sda) |-> !dev_sda_oe[*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("device drove after stop");

  property p_one_start;
    scl && $fell(sda) |=> (!(scl && $fell(sda)))[*6];
  endproperty
  a_one_start: assert property (p_one_start)
    else $error("two starts in one clock high");

  property p_data_stable;
    scl && $past(scl) && cnt_r != 4'h0 && cnt_r != 4'hA |-> $stable(sda);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("data moved while clock high");

  property p_oe_scl_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("device drive changed with clock high");
endmodule : scp_link_properties

`default_nettype wire

// [testbench/test_video_encoder_serial_control_port.sv]
// bench: controller and device joined by the link, driven over avalon-mm
// assumes the design files under core and the link checker
`timescale 1ns/1ps
`default_nettype none

module test_video_encoder_serial_control_port;
  logic clk;
  logic resetn;
  logic pin;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] vstd;
  logic [2:0] luma;
  logic [2:0] chroma;
  logic [31:0] rdv;
  logic [31:0] seed;
  logic ack;
  logic [7:0] rx;
  logic [7:0] mdl;
  logic [7:0] bad [3];
  int err_total;
  int checked;
  int cyc;

  scp_link_if i_scp_link_if ();
  scp_device i_scp_device (.link(i_scp_link_if), .clk(clk),
    .resetn(resetn), .addr_select_pin(pin), .video_standard_field(vstd),
    .luma_filter_field(luma), .chroma_filter_field(chroma));
  scp_host i_scp_host (.link(i_scp_link_if), .clk(clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));
  scp_link_properties i_scp_link_properties (.clk(clk), .resetn(resetn),
    .dev_sda_oe(i_scp_link_if.dev_sda_oe), .scl(i_scp_link_if.scl),
    .sda(i_scp_link_if.sda));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task end_of_test;
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task av(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rdv = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : av

  // one byte on the link, then status and received byte
  task op(input logic [11:0] c);
    av(4'h0, 1'b1, {20'h0, c});
    do av(4'h4, 1'b0, 32'h0); while (rdv[0] !== 1'b0);
    ack = rdv[1];
    av(4'h8, 1'b0, 32'h0);
    rx = rdv[7:0];
  endtask : op

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total++;
      end_of_test;
    end
  end

  initial
  begin
    resetn = 1'b0;
    pin = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
    seed = 32'h00014F8D;
    mdl = 8'h00;
    bad = '{8'h01, 8'h80, 8'h7F};
    err_total = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({chroma, luma, vstd}, mdl);
    av(4'hC, 1'b0, 32'h0);
    chk(rdv[7:0], 8'h00);
    // both addresses, each with write and read, at each select level
    for (int p = 0; p < 2; p++)
    begin
      pin <= p[0];
      repeat (4) @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
        op({2'h0, !i[0], 1'b1, 8'hA8 | i[7:0]});
        chk({7'h0, ack}, {7'h0, i[1] == p[0]});
        if (i[0])
          op(12'hE00);
      end
    end
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    // write one byte, overrun the top, read past it
    repeat (3)
    begin
      seed = lfsr(seed);
      op(12'h1A8);
      chk({7'h0, ack}, 8'h01);
      op(12'h000);
      chk({7'h0, ack}, 8'h01);
      op({4'h0, seed[7:0]});
      chk({7'h0, ack}, 8'h01);
      mdl = seed[7:0];
      op({4'h2, seed[15:8]});
      chk({7'h0, ack}, 8'h00);
      chk({chroma, luma, vstd}, mdl);
      op(12'h1A8);
      op(12'h000);
      op(12'h1A9);
      chk({7'h0, ack}, 8'h01);
      op(12'h400);
      chk(rx, mdl);
      op(12'h400);
      chk(rx, mdl);
      op(12'hE00);
      chk(rx, mdl);
    end
    // pointers that name no register
    foreach (bad[k])
    begin
      op(12'h1A8);
      op({4'h0, bad[k]});
      chk({7'h0, ack}, 8'h00);
      op({4'h2, ~mdl});
      chk({7'h0, ack}, 8'h00);
      chk({chroma, luma, vstd}, mdl);
    end
    end_of_test;
  end
endmodule : test_video_encoder_serial_control_port

`default_nettype wire
